// >>> core/isio_pkg.sv
// package: register map, fields, timing and modes of the pin block
package isio_pkg;

  typedef enum logic [1:0] {FN_PRIMARY, FN_INPUT, FN_OUTPUT} isio_fn_t;
  typedef enum logic [1:0] {OV_TRUE, OV_FALSE, OV_PWM} isio_oval_t;

  // byte addresses of the registers
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OUTEN = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_PWM_PER5 = 8'h0C;
  localparam logic [7:0] ADDR_PWM_DUTY5 = 8'h10;
  localparam logic [7:0] ADDR_PWM_PER6 = 8'h14;
  localparam logic [7:0] ADDR_PWM_DUTY6 = 8'h18;

  // control register fields: pin 5 in bits 0..5, pin 6 in bits 8..12
  localparam int P5_INV = 0;
  localparam int P5_FN = 1;
  localparam int P5_OV = 3;
  localparam int P5_LATCH = 5;
  localparam int P6_INV = 8;
  localparam int P6_FN = 9;
  localparam int P6_OV = 11;
  localparam logic [31:0] CTRL_MASK = 32'h0000_1F3F;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // status register fields
  localparam int ST_OUT_EN = 0;
  localparam int ST_ACTUAL = 1;
  localparam int ST_INH = 2;
  localparam int ST_PROT = 3;
  localparam int ST_PIN5 = 4;
  localparam int ST_PIN6 = 5;

  // outen register: bit 0 is 1 for on, 0 for off; bit 1 clears protection
  localparam int OE_ON = 0;
  localparam int OE_PCLR = 1;

  localparam logic [31:0] PWM_PER_RST = 32'h0000_0000;
  localparam logic [31:0] PWM_DUTY_RST = 32'h0000_0000;

  // pulse timing
  localparam int CLK_MHZ = 100;
  localparam int PULSE_MIN_US = 30;
  localparam int PULSE_MIN_CYC = PULSE_MIN_US * CLK_MHZ;
  localparam logic [15:0] PULSE_MIN_CNT = 16'(PULSE_MIN_CYC);

endpackage

// >>> core/isio_top.sv
// module: inhibit pin (5) and bidirectional sync-on pin (6) with apb registers
//
// Function
// - invert setting flips each pin's level both in and out
// - general output mode drives true, false or pwm
// - true drives low, or high when inverted
// - false drives high, or low when inverted
// - pwm frequency and duty come from separate settings
// - inhibit pin gates operation, in level or latched sub-mode
// - level mode: floating pin reads high and, when not inverted, leaves output alone
// - level mode, low pin, enabled: actual output zero, enable kept
// - level mode: inactive pin restores actual output by itself
// - level mode inverted: high level is the suppressing level
// - level inhibit active shows inhibit status and blocks output
// - latched mode: unconnected pin has no effect
// - latched mode: pulse while enabled clears output enable
// - latched inhibit sets protection; enable off until cleared, reenabled
// - exchanged pulses hold low level at least 30 us
// - sync-on pin is bidirectional, accepts and emits pulses
// - local off-to-on of output enable emits a sync pulse
// - sync pulse while already on changes nothing
// - sync pulse while off turns output enable on, unless protection is set
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module isio_top
  import isio_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic PIN5_I,
  output logic PIN5_O,
  output logic PIN5_OE,
  input wire logic PIN6_I,
  output logic PIN6_O,
  output logic PIN6_OE,
  output logic OUT_ENABLE,
  output logic ACTUAL_OUTPUT,
  output logic INHIBIT_ACTIVE_INDICATOR,
  output logic INHIBIT_PROTECTION_STATUS
);
  import isio_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave
  logic [31:0] ctrl_r;
  logic [31:0] per5_r;
  logic [31:0] duty5_r;
  logic [31:0] per6_r;
  logic [31:0] duty6_r;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic on_cmd;
  logic off_cmd;
  logic pclr_cmd;
  logic out_en_r;
  logic prot_r;
  logic inh_lvl;
  logic [31:0] stat;
  logic p5_s1_r;
  logic p5_s2_r;
  logic p5_s3_r;
  logic p5_lvl_r;
  logic p6_s1_r;
  logic p6_s2_r;
  logic p6_s3_r;
  logic p6_lvl_r;

  assign addr_ok = (PADDR == ADDR_CTRL) || (PADDR == ADDR_OUTEN) ||
                   (PADDR == ADDR_STAT) || (PADDR == ADDR_PWM_PER5) ||
                   (PADDR == ADDR_PWM_DUTY5) || (PADDR == ADDR_PWM_PER6) ||
                   (PADDR == ADDR_PWM_DUTY6);
  assign wr_en = PSEL && PENABLE && PWRITE && addr_ok;
  assign rd_en = PSEL && !PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  assign on_cmd = wr_en && (PADDR == ADDR_OUTEN) && PWDATA[OE_ON];
  assign off_cmd = wr_en && (PADDR == ADDR_OUTEN) && !PWDATA[OE_ON];
  assign pclr_cmd = wr_en && (PADDR == ADDR_OUTEN) && PWDATA[OE_PCLR];

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      ctrl_r <= CTRL_RST;
    else if (wr_en && (PADDR == ADDR_CTRL))
      ctrl_r <= PWDATA & CTRL_MASK;
  end

  // new pwm settings apply on the next count, the period is not restarted
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      per5_r <= PWM_PER_RST;
      duty5_r <= PWM_DUTY_RST;
      per6_r <= PWM_PER_RST;
      duty6_r <= PWM_DUTY_RST;
    end
    else if (wr_en)
    begin
      case (PADDR)
        ADDR_PWM_PER5: per5_r <= PWDATA;
        ADDR_PWM_DUTY5: duty5_r <= PWDATA;
        ADDR_PWM_PER6: per6_r <= PWDATA;
        ADDR_PWM_DUTY6: duty6_r <= PWDATA;
        default: ;
      endcase
    end
  end

  assign stat = {26'h000_0000, p6_lvl_r, p5_lvl_r, prot_r, inh_lvl,
                 ACTUAL_OUTPUT, out_en_r};

  // read data registered in setup so it stands through the access phase
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      PRDATA <= 32'h0000_0000;
    else if (rd_en)
    begin
      case (PADDR)
        ADDR_CTRL: PRDATA <= ctrl_r;
        ADDR_OUTEN: PRDATA <= {31'h0000_0000, out_en_r};
        ADDR_STAT: PRDATA <= stat;
        ADDR_PWM_PER5: PRDATA <= per5_r;
        ADDR_PWM_DUTY5: PRDATA <= duty5_r;
        ADDR_PWM_PER6: PRDATA <= per6_r;
        ADDR_PWM_DUTY6: PRDATA <= duty6_r;
        default: PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field decode
  logic inv5;
  logic inv6;
  logic latch5;
  isio_fn_t fn5;
  isio_fn_t fn6;
  isio_oval_t ov5;
  isio_oval_t ov6;

  assign inv5 = ctrl_r[P5_INV];
  assign inv6 = ctrl_r[P6_INV];
  assign latch5 = ctrl_r[P5_LATCH];
  assign fn5 = isio_fn_t'(ctrl_r[P5_FN +: 2]);
  assign fn6 = isio_fn_t'(ctrl_r[P6_FN +: 2]);
  assign ov5 = isio_oval_t'(ctrl_r[P5_OV +: 2]);
  assign ov6 = isio_oval_t'(ctrl_r[P6_OV +: 2]);

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchronisers; a change counts once stages 2 and 3 agree
  // reset high matches the pulled-up idle pin, so no false edge after reset
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      p5_s1_r <= 1'b1;
      p5_s2_r <= 1'b1;
      p5_s3_r <= 1'b1;
      p5_lvl_r <= 1'b1;
    end
    else
    begin
      p5_s1_r <= PIN5_I;
      p5_s2_r <= p5_s1_r;
      p5_s3_r <= p5_s2_r;
      if (p5_s2_r == p5_s3_r)
        p5_lvl_r <= p5_s3_r;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      p6_s1_r <= 1'b1;
      p6_s2_r <= 1'b1;
      p6_s3_r <= 1'b1;
      p6_lvl_r <= 1'b1;
    end
    else
    begin
      p6_s1_r <= PIN6_I;
      p6_s2_r <= p6_s1_r;
      p6_s3_r <= p6_s2_r;
      if (p6_s2_r == p6_s3_r)
        p6_lvl_r <= p6_s3_r;
    end
  end

  // active = low without inversion, high with it; a floating pin pulls high
  logic act5;
  logic act6;
  assign act5 = p5_lvl_r ^ ~inv5;
  assign act6 = p6_lvl_r ^ ~inv6;

  ////////////////////////////////////////////////////////////////////////////
  // pulse detectors: active long enough, then back to idle
  logic [15:0] w5_r;
  logic [15:0] w6_r;
  logic pulse5;
  logic pulse6;

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      w5_r <= 16'h0000;
      w6_r <= 16'h0000;
    end
    else
    begin
      if (!act5)
        w5_r <= 16'h0000;
      else if (w5_r != PULSE_MIN_CNT)
        w5_r <= w5_r + 16'h0001;
      if (!act6 || PIN6_OE)
        w6_r <= 16'h0000;
      else if (w6_r != PULSE_MIN_CNT)
        w6_r <= w6_r + 16'h0001;
    end
  end

  // the own emitted pulse is masked so it is not read back as a remote one
  assign pulse5 = !act5 && (w5_r == PULSE_MIN_CNT);
  assign pulse6 = !act6 && !PIN6_OE && (w6_r == PULSE_MIN_CNT);

  ////////////////////////////////////////////////////////////////////////////
  // output enable and protection
  logic latch_hit;
  logic sync_hit;
  assign latch_hit = (fn5 == FN_PRIMARY) && latch5 && pulse5 &&
                     out_en_r;
  assign sync_hit = (fn6 == FN_PRIMARY) && pulse6 && !out_en_r;
  assign inh_lvl = (fn5 == FN_PRIMARY) && !latch5 && act5;

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      prot_r <= 1'b0;
    else if (latch_hit)
      prot_r <= 1'b1;
    else if (pclr_cmd)
      prot_r <= 1'b0;
  end

  logic on_ok;
  logic emit_req;
  assign on_ok = on_cmd && !prot_r && !latch_hit;
  assign emit_req = on_ok && !out_en_r && (fn6 == FN_PRIMARY);

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      out_en_r <= 1'b0;
    else if (latch_hit || off_cmd)
      out_en_r <= 1'b0;
    else if (on_ok || (sync_hit && !prot_r))
      out_en_r <= 1'b1;
  end

  assign OUT_ENABLE = out_en_r;
  assign ACTUAL_OUTPUT = out_en_r && !inh_lvl;
  assign INHIBIT_ACTIVE_INDICATOR = inh_lvl;
  assign INHIBIT_PROTECTION_STATUS = prot_r;

  ////////////////////////////////////////////////////////////////////////////
  // sync-on pulse emitter: drives the active level for the minimum width
  logic [15:0] emit_r;
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      emit_r <= 16'h0000;
    else if (emit_req && emit_r == 16'h0000)
      emit_r <= PULSE_MIN_CNT;
    else if (emit_r != 16'h0000)
      emit_r <= emit_r - 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm generators
  logic [31:0] pc5_r;
  logic [31:0] pc6_r;
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      pc5_r <= 32'h0000_0000;
    else if (pc5_r >= per5_r)
      pc5_r <= 32'h0000_0000;
    else
      pc5_r <= pc5_r + 32'h0000_0001;
  end

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      pc6_r <= 32'h0000_0000;
    else if (pc6_r >= per6_r)
      pc6_r <= 32'h0000_0000;
    else
      pc6_r <= pc6_r + 32'h0000_0001;
  end

  // logical 1 means active (low without inversion)
  logic val5;
  logic val6;
  always_comb
  begin
    case (ov5)
      OV_TRUE: val5 = 1'b1;
      OV_FALSE: val5 = 1'b0;
      OV_PWM: val5 = (pc5_r < duty5_r);
      default: val5 = 1'b0;
    endcase
  end

  always_comb
  begin
    case (ov6)
      OV_TRUE: val6 = 1'b1;
      OV_FALSE: val6 = 1'b0;
      OV_PWM: val6 = (pc6_r < duty6_r);
      default: val6 = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers, registered
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PIN5_O <= 1'b1;
      PIN5_OE <= 1'b0;
    end
    else
    begin
      PIN5_OE <= (fn5 == FN_OUTPUT);
      PIN5_O <= ~val5 ^ inv5;
    end
  end

  // except in output mode or during a sync pulse the driver is off and the far pull-up sets the line
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PIN6_O <= 1'b1;
      PIN6_OE <= 1'b0;
    end
    else if (fn6 == FN_OUTPUT)
    begin
      PIN6_OE <= 1'b1;
      PIN6_O <= ~val6 ^ inv6;
    end
    else
    begin
      PIN6_OE <= (fn6 == FN_PRIMARY) && (emit_r != 16'h0000);
      PIN6_O <= inv6;
    end
  end

endmodule

`default_nettype wire

// >>> verif/isio_monitor.sv
// checker: bus and pin relations at the top ports of the pin block
`timescale 1ns/10ps
`default_nettype none
module isio_monitor
  import isio_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic PIN5_O,
  input wire logic PIN5_OE,
  input wire logic PIN6_O,
  input wire logic PIN6_OE,
  input wire logic OUT_ENABLE,
  input wire logic ACTUAL_OUTPUT,
  input wire logic INHIBIT_ACTIVE_INDICATOR,
  input wire logic INHIBIT_PROTECTION_STATUS
);
  ////////////////////////////////////////////////////////////
  logic [31:0] ctrl_r;
  logic [1:0] age_r;
  logic acc;
  logic on_wr;
  assign acc = PSEL && PENABLE;
  assign on_wr = acc && PWRITE && PADDR == ADDR_OUTEN && PWDATA[OE_ON];
  // shadow of control, with age so registered pins may settle
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ctrl_r <= CTRL_RST;
      age_r <= 2'h0;
    end
    else if (acc && PWRITE && PADDR == ADDR_CTRL)
    begin
      ctrl_r <= PWDATA & CTRL_MASK;
      age_r <= 2'h0;
    end
    else if (age_r != 2'h3)
      age_r <= age_r + 2'h1;
  end
  default clocking dc @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);
  ////////////////////////////////////////////////////////////
  pready_high_a: assert property (acc |-> PREADY)
    else $error("no ready in access phase");
  bad_addr_a: assert property (
    acc |-> PSLVERR == (PADDR > 8'h18 || PADDR[1:0] != 2'h0))
    else $error("error response wrong");
  actual_gate_a: assert property (
    ACTUAL_OUTPUT == (OUT_ENABLE && !INHIBIT_ACTIVE_INDICATOR))
    else $error("actual output not gated by inhibit");
  prot_off_a: assert property (
    $rose(INHIBIT_PROTECTION_STATUS) |-> ##[0:1] !OUT_ENABLE)
    else $error("protection left enable on");
  prot_hold_a: assert property (
    INHIBIT_PROTECTION_STATUS && !OUT_ENABLE |=> !OUT_ENABLE)
    else $error("enable rose under protection");
  sync_emit_a: assert property (
    on_wr && !OUT_ENABLE && !INHIBIT_PROTECTION_STATUS
    && ctrl_r[10:9] == FN_PRIMARY |-> ##[1:2] PIN6_OE)
    else $error("no sync pulse on local turn on");
  sync_level_a: assert property (
    PIN6_OE && age_r == 2'h3 && ctrl_r[10:9] == FN_PRIMARY
    |-> PIN6_O == ctrl_r[P6_INV])
    else $error("sync pulse at wrong level");
  true_level_a: assert property (
    age_r == 2'h3 && ctrl_r[2:1] == FN_OUTPUT && ctrl_r[4:3] == OV_TRUE
    |-> PIN5_OE && PIN5_O == ctrl_r[P5_INV])
    else $error("true value at wrong level");
  false_level_a: assert property (
    age_r == 2'h3 && ctrl_r[2:1] == FN_OUTPUT && ctrl_r[4:3] == OV_FALSE
    |-> PIN5_OE && PIN5_O == !ctrl_r[P5_INV])
    else $error("false value at wrong level");
  cover property (INHIBIT_ACTIVE_INDICATOR && OUT_ENABLE);
  cover property ($rose(INHIBIT_PROTECTION_STATUS));
  cover property ($rose(PIN6_OE));
endmodule
bind isio_top isio_monitor u_mon (
  .REF_CLK(REF_CLK),
  .RESETN(RESETN),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PWRITE(PWRITE),
  .PADDR(PADDR),
  .PWDATA(PWDATA),
  .PREADY(PREADY),
  .PSLVERR(PSLVERR),
  .PIN5_O(PIN5_O),
  .PIN5_OE(PIN5_OE),
  .PIN6_O(PIN6_O),
  .PIN6_OE(PIN6_OE),
  .OUT_ENABLE(OUT_ENABLE),
  .ACTUAL_OUTPUT(ACTUAL_OUTPUT),
  .INHIBIT_ACTIVE_INDICATOR(INHIBIT_ACTIVE_INDICATOR),
  .INHIBIT_PROTECTION_STATUS(INHIBIT_PROTECTION_STATUS)
);
`default_nettype wire

// >>> verif/isio_ext.sv
// partner: far instrument sinking pins 5 and 6, with pull-ups
`timescale 1ns/10ps
`default_nettype none
module isio_ext (
  input wire logic clk,
  input wire logic pin5_o,
  input wire logic pin5_oe,
  input wire logic pin6_o,
  input wire logic pin6_oe,
  output logic pin5_i,
  output logic pin6_i
);
  ////////////////////////////////////////////////////////////
  logic s5 = 1'b0;
  logic s6 = 1'b0;
  // open collector: a sink wins, otherwise the pull-up holds high
  assign pin5_i = !(s5 || (pin5_oe && !pin5_o));
  assign pin6_i = !(s6 || (pin6_oe && !pin6_o));
  // below 3000 cycles only when a test wants the pulse refused
  task automatic pulse(input int pin, input int len);
    @(posedge clk);
    if (pin == 5)
      s5 <= 1'b1;
    else
      s6 <= 1'b1;
    repeat (len) @(posedge clk);
    s5 <= 1'b0;
    s6 <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic hold(input logic v);
    @(posedge clk);
    s5 <= v;
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// testbench: register, output mode, inhibit and sync checks
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import isio_pkg::*;
  logic clk, rstn, psel, pen, pwr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, p5o, p5oe, p6o, p6oe, p5i, p6i;
  logic en, act, inhibit_active_indicator, prot;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  int m_en, m_prot, m_inh, n, n6, duty;
  isio_top u_dut (
    .REF_CLK(clk),
    .RESETN(rstn),
    .PSEL(psel),
    .PENABLE(pen),
    .PWRITE(pwr),
    .PADDR(paddr),
    .PWDATA(pwdata),
    .PRDATA(prdata),
    .PREADY(pready),
    .PSLVERR(pslverr),
    .PIN5_I(p5i),
    .PIN5_O(p5o),
    .PIN5_OE(p5oe),
    .PIN6_I(p6i),
    .PIN6_O(p6o),
    .PIN6_OE(p6oe),
    .OUT_ENABLE(en),
    .ACTUAL_OUTPUT(act),
    .INHIBIT_ACTIVE_INDICATOR(inhibit_active_indicator),
    .INHIBIT_PROTECTION_STATUS(prot)
  );
  isio_ext u_ext (
    .clk(clk),
    .pin5_o(p5o),
    .pin5_oe(p5oe),
    .pin6_o(p6o),
    .pin6_oe(p6oe),
    .pin5_i(p5i),
    .pin6_i(p6i)
  );
  ////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      bad_count++;
      results();
    end
  end
  task automatic results();
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // model state against status register and status pins
  task automatic stat();
    logic [3:0] e;
    repeat (8) @(posedge clk);
    e = {m_prot[0], m_inh[0], m_en[0] && !m_inh[0], m_en[0]};
    apb(1'b0, ADDR_STAT, 32'h0000_0000);
    chk(rd[3:0], e);
    chk({prot, inhibit_active_indicator, act, en}, e);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    {psel, pen, pwr, paddr, pwdata, rstn} = '0;
    m_en = 0;
    m_prot = 0;
    m_inh = 0;
    void'($urandom(80822));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, ADDR_CTRL, 32'h0000_0000);
    chk(rd, CTRL_RST);
    apb(1'b0, ADDR_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0030);
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk(err, 1'b1);
    // bit 0 of i inverts, bit 1 picks the false value
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, ADDR_CTRL, 32'h0404 | 32'h0101 * i[0] | 32'h0808 * i[1]);
      repeat (4) @(posedge clk);
      chk({p5oe, p5o, p6oe, p6o}, {2{1'b1, i[0] ^ i[1]}});
    end
    duty = 1 + int'($urandom % 8);
    apb(1'b1, ADDR_PWM_PER5, 32'h0000_0009);
    apb(1'b1, ADDR_PWM_DUTY5, 32'(duty));
    apb(1'b1, ADDR_PWM_PER6, 32'h0000_0009);
    apb(1'b1, ADDR_PWM_DUTY6, 32'(9 - duty));
    apb(1'b1, ADDR_CTRL, 32'h0000_1414);
    // the pins show the new mode one edge after the write lands
    repeat (2) @(posedge clk);
    n = 0;
    n6 = 0;
    repeat (40)
    begin
      @(negedge clk);
      n += int'(p5o == 1'b0);
      n6 += int'(p6o == 1'b0);
    end
    chk(n, 4 * duty);
    chk(n6, 4 * (9 - duty));
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, ADDR_OUTEN, 32'h0000_0001);
    m_en = 1;
    n = 0;
    repeat (3100) @(negedge clk) n += int'(p6oe && !p6o);
    chk(n >= 3000 && n <= 3001, 1'b1);
    stat();
    u_ext.hold(1'b1);
    m_inh = 1;
    stat();
    u_ext.hold(1'b0);
    m_inh = 0;
    stat();
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    m_inh = 1;
    stat();
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    m_inh = 0;
    u_ext.hold(1'b1);
    stat();
    chk(rd[5:4], 2'b10);
    u_ext.hold(1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    u_ext.pulse(6, 3100);
    stat();
    apb(1'b1, ADDR_CTRL, 32'h0000_0020);
    u_ext.pulse(5, 1000);
    stat();
    u_ext.pulse(5, 3100);
    m_en = 0;
    m_prot = 1;
    stat();
    apb(1'b1, ADDR_OUTEN, 32'h0000_0001);
    stat();
    apb(1'b1, ADDR_OUTEN, 32'h0000_0002);
    m_prot = 0;
    apb(1'b1, ADDR_OUTEN, 32'h0000_0001);
    m_en = 1;
    stat();
    repeat (3100) @(posedge clk);
    apb(1'b1, ADDR_OUTEN, 32'h0000_0000);
    m_en = 0;
    stat();
    u_ext.pulse(6, 3100);
    m_en = 1;
    stat();
    results();
  end
endmodule
`default_nettype wire
